// ---- rtl/fer_erase_checker.sv ----
// flash erase request checker returning the erase result word
// ----------------------------------------
// Behaviour
// - erase outcome returned as 32-bit result word when the routine completes
// - bit 6 set, no erase, when write enable low or error protect set
// - bit 5 set when user area erase failed or registers changed in branch
// - user boot area selected outside boot or programmer mode: execution error, nothing erased
// - user boot area erased only in boot or programmer mode
// - bit 4 set when key differs from 5A, clear when it matches
// - bit 3 set when the low byte of the block number exceeds the user area block range
// - bit 0 set when erase ended abnormally for any reason
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module fer_erase_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // erase request from the cpu
    input wire logic eraseRequest,
    input wire fer_pkg::fer_req_t eraseReq,
    // result word write from the cpu
    input wire logic resultWrite,
    input wire logic [31:0] resultWriteData,
    // flash status
    input wire logic write_enable_pin,
    input wire logic error_protect_flag,
    input wire logic bootOrProgrammerMode,
    input wire logic branchRegsChanged,
    // flash array handshake
    input wire logic arrayDone,
    input wire logic arrayFail,
    output logic eraseStart,
    output logic [7:0] erase_block_number,
    // result
    output logic [31:0] erase_result_word,
    output logic resultDone
);
    import fer_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    fer_state_t stateQ;
    fer_state_t stateD;
    fer_req_t reqQ;
    logic wePinSync;

    // the pin is asynchronous; the flag is on this clock and needs no sync
    fer_sync2 u_we_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .asyncIn(write_enable_pin),
        .syncOut(wePinSync)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    wire logic modeFail = !wePinSync || error_protect_flag;
    wire logic keyFail = reqQ.flashKey != KEY_VALID;
    wire logic blockFail = reqQ.eraseBlockParam[7:0] > BLOCK_LAST;
    // user boot area outside boot or programmer mode is refused
    wire logic areaFail = (reqQ.areaSelect == AREA_USER_BOOT)
        && !bootOrProgrammerMode;
    wire logic checksPass = !(modeFail || keyFail || blockFail || areaFail);
    wire logic checkEnd = stateQ == FER_CHECK;
    wire logic eraseEnd = (stateQ == FER_ERASING) && arrayDone;
    // branch register damage counts as an execution failure
    wire logic execFail = arrayFail || branchRegsChanged;

    wire logic [31:0] checkWord = (32'h0000_0001 << BIT_MODE_SETTING) * modeFail
        | (32'h0000_0001 << BIT_ERASE_EXEC) * areaFail
        | (32'h0000_0001 << BIT_KEY_VALUE) * keyFail
        | (32'h0000_0001 << BIT_BLOCK_SELECT) * blockFail
        | (32'h0000_0001 << BIT_SUCCESS_FAIL) * !checksPass;
    wire logic [31:0] execWord = (32'h0000_0001 << BIT_ERASE_EXEC) * execFail
        | (32'h0000_0001 << BIT_SUCCESS_FAIL) * execFail;

    always_comb
    begin
        stateD = stateQ;
        case (stateQ)
            FER_IDLE:
                if (eraseRequest)
                    stateD = FER_CHECK;
            FER_CHECK:
                stateD = checksPass ? FER_ERASING : FER_IDLE;
            FER_ERASING:
                if (arrayDone)
                    stateD = FER_IDLE;
            default:
                stateD = FER_IDLE;
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stateQ <= FER_IDLE;
            reqQ <= '0;
        end
        else
        begin
            stateQ <= stateD;
            if (stateQ == FER_IDLE && eraseRequest)
                reqQ <= eraseReq;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            erase_result_word <= RESULT_RESET;
            resultDone <= 1'b0;
            eraseStart <= 1'b0;
            erase_block_number <= 8'h00;
        end
        else
        begin
            // completion wins over a cpu write in the same cycle
            resultDone <= (checkEnd && !checksPass) || eraseEnd;
            eraseStart <= checkEnd && checksPass;
            if (checkEnd && checksPass)
                erase_block_number <= reqQ.eraseBlockParam[7:0];
            if (checkEnd && !checksPass)
                erase_result_word <= checkWord;
            else if (eraseEnd)
                erase_result_word <= execWord;
            else if (resultWrite)
                erase_result_word <= resultWriteData & RESULT_MASK;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    chk_mode_blocks_erase: assert property (
        (checkEnd && modeFail) |=> !eraseStart && resultDone
            && erase_result_word[BIT_MODE_SETTING] && erase_result_word[BIT_SUCCESS_FAIL])
        else $error("mode failure did not block erase");
    chk_key_bit: assert property (
        (checkEnd && !checksPass) |=> erase_result_word[BIT_KEY_VALUE] == $past(keyFail))
        else $error("key bit does not match key check");
    chk_block_bit: assert property (
        (checkEnd && !checksPass) |=> erase_result_word[BIT_BLOCK_SELECT] == $past(blockFail))
        else $error("block bit does not match block check");
    chk_boot_area_guard: assert property (
        eraseStart |-> !((reqQ.areaSelect == AREA_USER_BOOT) && !bootOrProgrammerMode))
        else $error("user boot area erased outside boot mode");
    chk_exec_fail_flag: assert property (
        (eraseEnd && execFail) |=> resultDone && erase_result_word[BIT_ERASE_EXEC])
        else $error("execution failure not reported");
    chk_sf_any_error: assert property (
        resultDone |-> erase_result_word[BIT_SUCCESS_FAIL]
            == |erase_result_word[BIT_MODE_SETTING:BIT_BLOCK_SELECT])
        else $error("success flag disagrees with error bits");
    chk_unused_zero: assert property (
        (erase_result_word & ~RESULT_MASK) == 32'h0000_0000)
        else $error("unused result bits not zero");
    chk_start_when_clean: assert property (
        eraseStart |-> $past(checkEnd) && $past(checksPass) && stateQ == FER_ERASING)
        else $error("erase started without passing checks");
    chk_done_pulse: assert property (
        resultDone |=> !resultDone)
        else $error("done longer than one cycle");

    // ----------------------------------------
    // extra guards
    // ----------------------------------------
    // the block handed to the array must be the one that was checked
    chk_block_latch: assert property (
        eraseStart |-> erase_block_number == reqQ.eraseBlockParam[7:0])
        else $error("erase block number differs from request");
    // a refused request must never reach the array
    chk_refused_no_start: assert property (
        (checkEnd && !checksPass) |=> !eraseStart)
        else $error("refused request started an erase");
    // in idle no completion competes, so a cpu write lands masked
    chk_cpu_write_mask: assert property (
        (resultWrite && stateQ == FER_IDLE)
            |=> erase_result_word == ($past(resultWriteData) & RESULT_MASK))
        else $error("cpu write not masked into result word");

    cov_erase_ok: cover property (eraseStart ##[1:20] (resultDone && !erase_result_word[0]));
    cov_exec_fail: cover property (eraseEnd && execFail);
    cov_key_error: cover property (resultDone && erase_result_word[BIT_KEY_VALUE]);
    cov_boot_refused: cover property (checkEnd && areaFail);
endmodule
`default_nettype wire

// ---- rtl/fer_pkg.sv ----
// constants and types shared by the flash erase result checker
package fer_pkg;

    // ----------------------------------------
    // result word layout
    // ----------------------------------------
    localparam int RESULT_W = 32;
    localparam int BIT_MODE_SETTING = 6;
    localparam int BIT_ERASE_EXEC = 5;
    localparam int BIT_KEY_VALUE = 4;
    localparam int BIT_BLOCK_SELECT = 3;
    localparam int BIT_SUCCESS_FAIL = 0;
    localparam logic [31:0] RESULT_MASK = 32'h0000_0079;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

    // ----------------------------------------
    // check values
    // ----------------------------------------
    localparam logic [7:0] KEY_VALID = 8'h5A;
    localparam logic [7:0] BLOCK_LAST = 8'h0B;
    localparam logic [7:0] AREA_USER_BOOT = 8'hAA;

    // ----------------------------------------
    // request carrier
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] flashKey;
        logic [7:0] areaSelect;
        logic [31:0] eraseBlockParam;
    } fer_req_t;

    typedef enum logic [1:0] {
        FER_IDLE,
        FER_CHECK,
        FER_ERASING
    } fer_state_t;

endpackage

// ---- rtl/fer_sync2.sv ----
// two-stage synchroniser for a level from a pin
`timescale 1ns/1ps
`default_nettype none
module fer_sync2 (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // level
    input wire logic asyncIn,
    output logic syncOut
);
    logic metaQ;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            metaQ <= 1'b0;
            syncOut <= 1'b0;
        end
        else
        begin
            metaQ <= asyncIn;
            syncOut <= metaQ;
        end
    end
endmodule
`default_nettype wire

// ---- test/fer_testbench.sv ----
// self-checking bench for the flash erase result checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); n_fail++; end end
module testbench;
    import fer_pkg::*;
    // flags are {pin, protect, boot mode, array fail, branch change}
    typedef struct {
        logic [7:0] key;
        logic [7:0] area;
        logic [4:0] flg;
        logic [31:0] blk;
        logic [31:0] exp;
        logic start;
    } fer_row_t;
    logic sys_clk = 1'h0;
    logic arst_n = 1'h0;
    logic eraseRequest = 1'h0;
    fer_req_t eraseReq = '0;
    logic resultWrite = 1'h0;
    logic [31:0] resultWriteData = 32'h0;
    logic [4:0] flg = 5'h10;
    logic arrayDone = 1'h0;
    logic eraseStart;
    logic [7:0] erase_block_number;
    logic [31:0] erase_result_word;
    logic resultDone;
    int n_fail = 0;
    int compares = 0;
    int n;
    fer_row_t rows[12] = '{
        '{8'h5A, 8'h00, 5'h10, 32'h5, 32'h0, 1'h1},
        '{8'h5A, 8'h00, 5'h12, 32'hB, 32'h21, 1'h1},
        '{8'h5A, 8'h00, 5'h11, 32'h0, 32'h21, 1'h1},
        '{8'h5A, 8'h00, 5'h10, 32'h100, 32'h0, 1'h1},
        '{8'h5A, 8'h00, 5'h10, 32'hC, 32'h9, 1'h0},
        '{8'h5A, 8'h00, 5'h10, 32'hFF, 32'h9, 1'h0},
        '{8'h00, 8'h00, 5'h10, 32'h1, 32'h11, 1'h0},
        '{8'h5B, 8'h00, 5'h10, 32'h1, 32'h11, 1'h0},
        '{8'h5A, 8'h00, 5'h00, 32'h1, 32'h41, 1'h0},
        '{8'h5A, 8'h00, 5'h18, 32'h1, 32'h41, 1'h0},
        '{8'h5A, 8'hAA, 5'h10, 32'h1, 32'h21, 1'h0},
        '{8'h5A, 8'hAA, 5'h14, 32'h1, 32'h0, 1'h1}
    };

    fer_erase_checker fer_erase_checker_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .eraseRequest(eraseRequest),
        .eraseReq(eraseReq), .resultWrite(resultWrite), .resultWriteData(resultWriteData),
        .write_enable_pin(flg[4]), .error_protect_flag(flg[3]),
        .bootOrProgrammerMode(flg[2]), .branchRegsChanged(flg[0]),
        .arrayDone(arrayDone), .arrayFail(flg[1]), .eraseStart(eraseStart),
        .erase_block_number(erase_block_number), .erase_result_word(erase_result_word),
        .resultDone(resultDone)
    );

    always #12.5 sys_clk = ~sys_clk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // bounded wait for a done or start pulse, counted in cycles
    task automatic wait_out(output int k);
        k = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        while (resultDone !== 1'h1 && eraseStart !== 1'h1 && k < 10);
    endtask

    task automatic run(input fer_row_t r);
        @(posedge sys_clk);
        flg <= r.flg;
        eraseReq <= '{r.key, r.area, r.blk};
        // pin goes through a two-flop sync, so let it settle first
        repeat (3) @(posedge sys_clk);
        eraseRequest <= 1'h1;
        @(posedge sys_clk);
        eraseRequest <= 1'h0;
        wait_out(n);
        `CHK("latency", 1, n)
        `CHK("erase start", r.start, eraseStart)
        if (eraseStart === 1'h1)
        begin
            `CHK("block number", r.blk[7:0], erase_block_number)
            @(posedge sys_clk);
            arrayDone <= 1'h1;
            @(posedge sys_clk);
            arrayDone <= 1'h0;
            // done is registered on the edge that takes arrayDone and lasts one cycle
            #1;
        end
        `CHK("done pulse", 1'h1, resultDone)
        `CHK("result word", r.exp, erase_result_word)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge sys_clk);
        `CHK("reset word", RESULT_RESET, erase_result_word)
        arst_n <= 1'h1;
        foreach (rows[i])
            run(rows[i]);
        // cpu write keeps only the defined bits
        @(posedge sys_clk);
        resultWrite <= 1'h1;
        resultWriteData <= 32'hFFFF_FFFF;
        @(posedge sys_clk);
        resultWrite <= 1'h0;
        #1;
        `CHK("cpu write", RESULT_MASK, erase_result_word)
        // a bad request arriving mid-erase must be ignored
        eraseReq <= '{8'h5A, 8'h00, 32'h3};
        eraseRequest <= 1'h1;
        @(posedge sys_clk);
        eraseRequest <= 1'h0;
        wait_out(n);
        @(posedge sys_clk);
        eraseReq <= '{8'h00, 8'h00, 32'hFF};
        eraseRequest <= 1'h1;
        @(posedge sys_clk);
        eraseRequest <= 1'h0;
        arrayDone <= 1'h1;
        @(posedge sys_clk);
        arrayDone <= 1'h0;
        #1;
        `CHK("busy done", 1'h1, resultDone)
        `CHK("busy request", 32'h0, erase_result_word)
        // reset in mid-run clears a standing error word
        run(rows[6]);
        @(posedge sys_clk);
        arst_n <= 1'h0;
        @(posedge sys_clk);
        #1;
        `CHK("mid reset word", RESULT_RESET, erase_result_word)
        `CHK("mid reset start", 1'h0, eraseStart)
        @(posedge sys_clk);
        arst_n <= 1'h1;
        run(rows[0]);
        close_out();
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
